// [hdl/display_cmd_handler.sv]
// Standard display command handler: command decode, reset defaults, readback
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "display_cmd_regs.svh"

// Behaviour
// [RULE1] No-operation changes nothing and ends any running parameter sequence.
// [RULE2] Soft reset reloads soft defaults; frame memory is untouched.
// [RULE3] Soft reset blanks display, loads defaults, then enters sleep-in mode.
// [RULE4] Host waits 5 ms after soft reset before any further command.
// [RULE5] After soft reset in sleep-in, host waits 120 ms before sleep exit.
// [RULE6] Host should send soft reset only while in sleep-in mode.
// [RULE7] Ident read returns manufacturer, version, module identifier bytes in order.
// [RULE8] Ident byte two: bit 7 panel type, bits 6..0 version.
// [RULE9] Parity read: low seven bits count errors, bit 7 marks overflow.
// [RULE10] After parity read completes, clear count and signal-mode bit 0.
// [RULE11] Red readback: bits 5..1, 5..0 or 7..0 by format, rest zero.
// [RULE12] Green readback: bits 5..0 for 16/18-bit, all bits for 24-bit.
// [RULE13] Blue readback: bits 5..1, 5..0 or 7..0 by format, rest zero.
// [RULE14] Power-mode byte defaults to 0x08 after every reset.
// [RULE15] Pixel format defaults to 0x07; soft reset leaves it unchanged.
// [RULE16] Access control defaults to 0x00; soft reset leaves it unchanged.
// [RULE17] Gamma curve selection defaults to 0x01 after every reset.
// [RULE18] After any reset: sleep-in, normal mode on, display output off.
// [RULE19] After any reset: tear, inversion, idle, all-lit off; all-dark reported.
// [RULE20] Tear scanline, scanline readback, vertical scroll default to 0x0000; the scanline readback here returns i_scanline as driven, with no reset value.
// [RULE21] Brightness, display control, adaptive control, minimum brightness default 0x00.
// [RULE22] Ident bytes are reloaded from programmable storage after every reset.
// [RULE23] Power-mode bit 3 reports normal display mode.
// [RULE24] Read answers stream in order; commands during reset wait may be ignored.
module display_cmd_handler #(
	parameter int SWRST_WAIT_CYCLES = `SWRST_WAIT_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_byte,
	input  wire logic        i_param_valid,
	input  wire logic [7:0]  i_param_byte,
	output logic             o_rsp_valid,
	output logic      [7:0]  o_rsp_byte,
	output logic             o_rsp_last,
	input  wire logic        i_link_clk,
	input  wire logic        i_link_perr,
	input  wire logic [7:0]  i_pix_red,
	input  wire logic [7:0]  i_pix_green,
	input  wire logic [7:0]  i_pix_blue,
	input  wire logic [15:0] i_scanline,
	input  wire logic [7:0]  i_otp_id1,
	input  wire logic        i_otp_panel_module,
	input  wire logic [6:0]  i_otp_version,
	input  wire logic [7:0]  i_otp_id3,
	output logic             o_busy,
	output logic             o_sleep_in,
	output logic             o_display_on,
	output logic             o_normal_mode,
	output logic             o_inversion_on,
	output logic             o_idle_on,
	output logic             o_all_lit,
	output logic             o_tear_on,
	output logic      [7:0]  o_pixel_format,
	output logic      [7:0]  o_access_ctrl,
	output logic      [7:0]  o_gamma,
	output logic      [7:0]  o_brightness
);

	// Link clock and parity error pin are resynchronised before use
	logic [2:0] lclk_sync_q;
	logic [1:0] perr_sync_q;
	logic       perr_event;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lclk_sync_q <= 3'h0;
			perr_sync_q <= 2'h0;
		end else begin
			lclk_sync_q <= {lclk_sync_q[1:0], i_link_clk};
			perr_sync_q <= {perr_sync_q[0], i_link_perr};
		end
	end

	assign perr_event = lclk_sync_q[1] & ~lclk_sync_q[2] & perr_sync_q[1];

	display_cmd_pkg::state_type state_q, state_d;
	logic [20:0] wait_q, wait_d;
	logic [7:0]  ctrl_q, ctrl_d;
	logic [7:0]  cur_cmd_q, cur_cmd_d;
	logic [1:0]  pidx_q, pidx_d;
	logic        sleep_q, sleep_d, disp_q, disp_d, normal_q, normal_d;
	logic        inv_q, inv_d, idle_q, idle_d, lit_q, lit_d, te_q, te_d, te_mode_q, te_mode_d;
	logic [7:0]  fmt_q, fmt_d, memory_access_control_q, memory_access_control_d, gamma_q, gamma_d;
	logic [15:0] tear_scanline_set_q, tear_scanline_set_d, vscr_q, vscr_d;
	logic [7:0]  bright_q, bright_d, dctrl_q, dctrl_d, cabc_q, cabc_d, cabcmb_q, cabcmb_d;
	logic [7:0]  id1_q, id1_d, id2_q, id2_d, id3_q, id3_d;
	logic [6:0]  perr_cnt_q, perr_cnt_d;
	logic        perr_ovf_q, perr_ovf_d, sig_perr_q, sig_perr_d;
	logic [7:0]  rsp_q [3];
	logic [7:0]  rsp_d [3];
	logic [1:0]  rsp_left_q, rsp_left_d;
	logic        rsp_perr_q, rsp_perr_d;
	logic        rsp_valid_q, rsp_valid_d, rsp_last_q, rsp_last_d;
	logic [7:0]  rsp_byte_q, rsp_byte_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0]  power_mode, signal_mode;
	logic [7:0]  red_rb, green_rb, blue_rb;
	logic        accept;

	assign power_mode = {~sleep_q, idle_q, 1'b0, ~sleep_q, normal_q, disp_q, 2'b00}; // [RULE23]
	assign signal_mode = {te_q, te_mode_q, 5'h00, sig_perr_q};
	assign accept = (state_q == display_cmd_pkg::ST_IDLE) ||
			((state_q == display_cmd_pkg::ST_WAIT) && !ctrl_q[`CTRL_IGNORE_BIT]); // [RULE24]

	// First pixel readback aligned per interface format, unused bits zero
	always_comb begin
		case (fmt_q[2:0])
			`FMT_16BIT: begin
				red_rb   = {2'b00, i_pix_red[7:3], 1'b0};   // [RULE11]
				green_rb = {2'b00, i_pix_green[7:2]};       // [RULE12]
				blue_rb  = {2'b00, i_pix_blue[7:3], 1'b0};  // [RULE13]
			end
			`FMT_18BIT: begin
				red_rb   = {2'b00, i_pix_red[7:2]};         // [RULE11]
				green_rb = {2'b00, i_pix_green[7:2]};       // [RULE12]
				blue_rb  = {2'b00, i_pix_blue[7:2]};        // [RULE13]
			end
			default: begin
				red_rb   = i_pix_red;
				green_rb = i_pix_green;
				blue_rb  = i_pix_blue;
			end
		endcase
	end

	always_comb begin
		state_d = state_q;
		wait_d = wait_q;
		ctrl_d = ctrl_q;
		cur_cmd_d = cur_cmd_q;
		pidx_d = pidx_q;
		sleep_d = sleep_q;
		disp_d = disp_q;
		normal_d = normal_q;
		inv_d = inv_q;
		idle_d = idle_q;
		lit_d = lit_q;
		te_d = te_q;
		te_mode_d = te_mode_q;
		fmt_d = fmt_q;
		memory_access_control_d = memory_access_control_q;
		gamma_d = gamma_q;
		tear_scanline_set_d = tear_scanline_set_q;
		vscr_d = vscr_q;
		bright_d = bright_q;
		dctrl_d = dctrl_q;
		cabc_d = cabc_q;
		cabcmb_d = cabcmb_q;
		id1_d = id1_q;
		id2_d = id2_q;
		id3_d = id3_q;
		perr_cnt_d = perr_cnt_q;
		perr_ovf_d = perr_ovf_q;
		sig_perr_d = sig_perr_q;
		rsp_d = rsp_q;
		rsp_left_d = rsp_left_q;
		rsp_perr_d = rsp_perr_q;
		rsp_valid_d = 1'b0;
		rsp_last_d = 1'b0;
		rsp_byte_d = rsp_byte_q;
		rdata_d = 32'h0000_0000;

		// Register bus
		if (i_wr && i_addr == `REG_CTRL_OFS) begin
			ctrl_d = i_wdata[7:0];
		end
		if (i_rd) begin
			case (i_addr)
				`REG_STATUS_OFS: rdata_d = {24'h00_0000, o_busy, 4'h0, state_q};
				`REG_CTRL_OFS:   rdata_d = {24'h00_0000, ctrl_q};
				`REG_MODES_OFS:  rdata_d = {16'h0000, signal_mode, power_mode};
				`REG_PERR_OFS:   rdata_d = {24'h00_0000, perr_ovf_q, perr_cnt_q};
				default:         rdata_d = 32'h0000_0000;
			endcase
		end

		// Read answer streams one byte per cycle, first byte first
		if (rsp_left_q != 2'h0) begin
			rsp_valid_d = 1'b1;
			rsp_byte_d = rsp_q[0];
			rsp_last_d = (rsp_left_q == 2'h1);
			rsp_d[0] = rsp_q[1];
			rsp_d[1] = rsp_q[2];
			rsp_left_d = rsp_left_q - 2'h1;
			if (rsp_left_q == 2'h1 && rsp_perr_q) begin
				perr_cnt_d = 7'h00; // [RULE10]
				perr_ovf_d = 1'b0;  // [RULE10]
				sig_perr_d = 1'b0;  // [RULE10]
				rsp_perr_d = 1'b0;
			end
		end

		if (i_cmd_valid && accept) begin
			cur_cmd_d = i_cmd_byte;
			pidx_d = 2'h0;
			rsp_left_d = 2'h0;
			rsp_perr_d = 1'b0;
			case (i_cmd_byte)
				display_cmd_pkg::NOP_CMD: cur_cmd_d = 8'h00; // [RULE1]
				display_cmd_pkg::SOFT_RESET_CMD: state_d = display_cmd_pkg::ST_BLANK; // [RULE2]
				display_cmd_pkg::READ_IDENT_INFO_CMD: begin
					rsp_d[0] = id1_q; // [RULE7]
					rsp_d[1] = id2_q;
					rsp_d[2] = id3_q;
					rsp_left_d = 2'h3;
				end
				display_cmd_pkg::READ_PARITY_ERR_COUNT_CMD: begin
					rsp_d[0] = {perr_ovf_q, perr_cnt_q}; // [RULE9]
					rsp_left_d = 2'h1;
					rsp_perr_d = 1'b1;
				end
				display_cmd_pkg::READ_FIRST_PIXEL_RED_CMD: begin
					rsp_d[0] = red_rb;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::READ_FIRST_PIXEL_GREEN_CMD: begin
					rsp_d[0] = green_rb;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::READ_FIRST_PIXEL_BLUE_CMD: begin
					rsp_d[0] = blue_rb;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::READ_POWER_MODE_CMD: begin
					rsp_d[0] = power_mode;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::READ_ACCESS_CONTROL_CMD: begin
					rsp_d[0] = memory_access_control_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::READ_PIXEL_FORMAT_CMD: begin
					rsp_d[0] = fmt_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::READ_SIGNAL_MODE_CMD: begin
					rsp_d[0] = signal_mode;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::CURRENT_SCANLINE_READ: begin
					rsp_d[0] = i_scanline[15:8];
					rsp_d[1] = i_scanline[7:0];
					rsp_left_d = 2'h2;
				end
				display_cmd_pkg::BRIGHTNESS_VALUE_READ: begin
					rsp_d[0] = bright_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::DISPLAY_CTRL_READ: begin
					rsp_d[0] = dctrl_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::ADAPTIVE_BRIGHTNESS_READ: begin
					rsp_d[0] = cabc_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::ADAPTIVE_MIN_BRIGHTNESS_READ: begin
					rsp_d[0] = cabcmb_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::IDENT_BYTE_ONE_READ: begin
					rsp_d[0] = id1_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::IDENT_BYTE_TWO_READ: begin
					rsp_d[0] = id2_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::IDENT_BYTE_THREE_READ: begin
					rsp_d[0] = id3_q;
					rsp_left_d = 2'h1;
				end
				display_cmd_pkg::SLEEP_ENTER_CMD:        sleep_d = 1'b1;
				display_cmd_pkg::SLEEP_EXIT_CMD:         sleep_d = 1'b0;
				display_cmd_pkg::FULL_AREA_MODE_ON_CMD:  normal_d = 1'b1;
				display_cmd_pkg::INVERSION_OFF_CMD:      inv_d = 1'b0;
				display_cmd_pkg::INVERSION_ON_CMD:       inv_d = 1'b1;
				display_cmd_pkg::FORCE_PIXELS_DARK_CMD:  lit_d = 1'b0;
				display_cmd_pkg::FORCE_PIXELS_LIT_CMD:   lit_d = 1'b1;
				display_cmd_pkg::PANEL_OUTPUT_OFF_CMD:   disp_d = 1'b0;
				display_cmd_pkg::PANEL_OUTPUT_ON_CMD:    disp_d = 1'b1;
				display_cmd_pkg::TEAR_OUTPUT_OFF_CMD:    te_d = 1'b0;
				display_cmd_pkg::TEAR_OUTPUT_ON_CMD:     te_d = 1'b1;
				display_cmd_pkg::LOW_COLOR_OFF_CMD:      idle_d = 1'b0;
				display_cmd_pkg::LOW_COLOR_ON_CMD:       idle_d = 1'b1;
				default: ;
			endcase
		end else if (i_param_valid && accept) begin
			pidx_d = (pidx_q == 2'h3) ? pidx_q : pidx_q + 2'h1;
			case (cur_cmd_q)
				display_cmd_pkg::GAMMA_CURVE_SELECT:        gamma_d = i_param_byte;
				display_cmd_pkg::TEAR_OUTPUT_ON_CMD:        te_mode_d = i_param_byte[0];
				display_cmd_pkg::MEMORY_ACCESS_CONTROL:     memory_access_control_d = {i_param_byte[7:2], 2'b00};
				display_cmd_pkg::INTERFACE_PIXEL_FORMAT:    fmt_d = i_param_byte & 8'h77;
				display_cmd_pkg::BRIGHTNESS_VALUE_WRITE:    bright_d = i_param_byte;
				display_cmd_pkg::DISPLAY_CTRL_WRITE:        dctrl_d = i_param_byte & 8'h2c;
				display_cmd_pkg::ADAPTIVE_BRIGHTNESS_WRITE: cabc_d = i_param_byte & 8'hf3;
				display_cmd_pkg::ADAPTIVE_MIN_BRIGHTNESS_WRITE: cabcmb_d = i_param_byte;
				display_cmd_pkg::TEAR_SCANLINE_SET: begin
					if (pidx_q == 2'h0) tear_scanline_set_d[15:8] = i_param_byte;
					else if (pidx_q == 2'h1) tear_scanline_set_d[7:0] = i_param_byte;
				end
				display_cmd_pkg::VERTICAL_SCROLL_ADDRESS: begin
					if (pidx_q == 2'h0) vscr_d[15:8] = i_param_byte;
					else if (pidx_q == 2'h1) vscr_d[7:0] = i_param_byte;
				end
				default: ;
			endcase
		end

		// Reset sequencer
		case (state_q)
			display_cmd_pkg::ST_OTP: begin
				id1_d = i_otp_id1;                              // [RULE22]
				id2_d = {i_otp_panel_module, i_otp_version};    // [RULE8]
				id3_d = i_otp_id3;
				state_d = display_cmd_pkg::ST_IDLE;
			end
			display_cmd_pkg::ST_IDLE: ;
			display_cmd_pkg::ST_BLANK: begin
				disp_d = 1'b0; // [RULE3]
				state_d = display_cmd_pkg::ST_LOAD;
			end
			display_cmd_pkg::ST_LOAD: begin
				// Pixel format and access control survive a soft reset
				sleep_d = 1'b1;      // [RULE3] [RULE18]
				disp_d = 1'b0;
				normal_d = 1'b1;
				inv_d = 1'b0;        // [RULE19]
				idle_d = 1'b0;
				lit_d = 1'b0;
				te_d = 1'b0;
				te_mode_d = 1'b0;
				gamma_d = `GAMMA_RST;   // [RULE17]
				tear_scanline_set_d = `WORD_ZERO_RST; // [RULE20]
				vscr_d = `WORD_ZERO_RST;
				bright_d = `BYTE_ZERO_RST; // [RULE21]
				dctrl_d = `BYTE_ZERO_RST;
				cabc_d = `BYTE_ZERO_RST;
				cabcmb_d = `BYTE_ZERO_RST;
				id1_d = i_otp_id1;      // [RULE22]
				id2_d = {i_otp_panel_module, i_otp_version};
				id3_d = i_otp_id3;
				perr_cnt_d = 7'h00;
				perr_ovf_d = 1'b0;
				sig_perr_d = 1'b0;
				rsp_left_d = 2'h0;
				cur_cmd_d = 8'h00;
				wait_d = 21'(SWRST_WAIT_CYCLES - 1);
				state_d = display_cmd_pkg::ST_WAIT;
			end
			display_cmd_pkg::ST_WAIT: begin
				if (wait_q == 21'h0) state_d = display_cmd_pkg::ST_IDLE; // [RULE4]
				else wait_d = wait_q - 21'h1;
				if (i_cmd_valid && accept && i_cmd_byte == display_cmd_pkg::SOFT_RESET_CMD)
					state_d = display_cmd_pkg::ST_BLANK;
			end
			default: state_d = display_cmd_pkg::ST_IDLE;
		endcase

		// A parity error landing with a clear is kept
		if (perr_event) begin
			sig_perr_d = 1'b1;
			if (perr_cnt_d == `PERR_MAX) perr_ovf_d = 1'b1; // [RULE9]
			else perr_cnt_d = perr_cnt_d + 7'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= display_cmd_pkg::ST_OTP;
			wait_q <= 21'h0;
			ctrl_q <= `CTRL_RST;
			cur_cmd_q <= 8'h00;
			pidx_q <= 2'h0;
			sleep_q <= 1'b1;      // [RULE18] [RULE14]
			disp_q <= 1'b0;
			normal_q <= 1'b1;
			inv_q <= 1'b0;        // [RULE19]
			idle_q <= 1'b0;
			lit_q <= 1'b0;
			te_q <= 1'b0;
			te_mode_q <= 1'b0;
			fmt_q <= `PIXEL_FORMAT_RST;  // [RULE15]
			memory_access_control_q <= `ACCESS_CTRL_RST; // [RULE16]
			gamma_q <= `GAMMA_RST;        // [RULE17]
			tear_scanline_set_q <= `WORD_ZERO_RST;     // [RULE20]
			vscr_q <= `WORD_ZERO_RST;
			bright_q <= `BYTE_ZERO_RST;   // [RULE21]
			dctrl_q <= `BYTE_ZERO_RST;
			cabc_q <= `BYTE_ZERO_RST;
			cabcmb_q <= `BYTE_ZERO_RST;
			id1_q <= 8'h00;
			id2_q <= 8'h00;
			id3_q <= 8'h00;
			perr_cnt_q <= 7'h00;
			perr_ovf_q <= 1'b0;
			sig_perr_q <= 1'b0;
			rsp_q <= '{8'h00, 8'h00, 8'h00};
			rsp_left_q <= 2'h0;
			rsp_perr_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_last_q <= 1'b0;
			rsp_byte_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			wait_q <= wait_d;
			ctrl_q <= ctrl_d;
			cur_cmd_q <= cur_cmd_d;
			pidx_q <= pidx_d;
			sleep_q <= sleep_d;
			disp_q <= disp_d;
			normal_q <= normal_d;
			inv_q <= inv_d;
			idle_q <= idle_d;
			lit_q <= lit_d;
			te_q <= te_d;
			te_mode_q <= te_mode_d;
			fmt_q <= fmt_d;
			memory_access_control_q <= memory_access_control_d;
			gamma_q <= gamma_d;
			tear_scanline_set_q <= tear_scanline_set_d;
			vscr_q <= vscr_d;
			bright_q <= bright_d;
			dctrl_q <= dctrl_d;
			cabc_q <= cabc_d;
			cabcmb_q <= cabcmb_d;
			id1_q <= id1_d;
			id2_q <= id2_d;
			id3_q <= id3_d;
			perr_cnt_q <= perr_cnt_d;
			perr_ovf_q <= perr_ovf_d;
			sig_perr_q <= sig_perr_d;
			rsp_q <= rsp_d;
			rsp_left_q <= rsp_left_d;
			rsp_perr_q <= rsp_perr_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_last_q <= rsp_last_d;
			rsp_byte_q <= rsp_byte_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_rsp_valid = rsp_valid_q;
	assign o_rsp_byte = rsp_byte_q;
	assign o_rsp_last = rsp_last_q;
	assign o_busy = (state_q != display_cmd_pkg::ST_IDLE);
	assign o_sleep_in = sleep_q;
	assign o_display_on = disp_q;
	assign o_normal_mode = normal_q;
	assign o_inversion_on = inv_q;
	assign o_idle_on = idle_q;
	assign o_all_lit = lit_q;
	assign o_tear_on = te_q;
	assign o_pixel_format = fmt_q;
	assign o_access_ctrl = memory_access_control_q;
	assign o_gamma = gamma_q;
	assign o_brightness = bright_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	AST_NOP_KEEPS: assert property ((i_cmd_valid && accept && i_cmd_byte == 8'h00) |=> // [RULE1]
		$stable(disp_q) && $stable(sleep_q) && $stable(gamma_q))
		else $error("no-operation changed display state");
	AST_SWRST_KEEPS_FMT: assert property ((state_q == display_cmd_pkg::ST_LOAD) |=> // [RULE15]
		$stable(fmt_q) && $stable(memory_access_control_q))
		else $error("soft reset altered format or access control");
	AST_SWRST_SEQ: assert property ((i_cmd_valid && accept && i_cmd_byte == 8'h01) |=> // [RULE3]
		(state_q == display_cmd_pkg::ST_BLANK) ##1 !disp_q ##1 (sleep_q && !disp_q && gamma_q == 8'h01))
		else $error("soft reset sequence out of order");
	AST_IDENT_ORDER: assert property ((i_cmd_valid && accept && i_cmd_byte == 8'h04) |=> // [RULE7]
		##1 (o_rsp_valid && o_rsp_byte == id1_q) ##1 (o_rsp_byte == id2_q) ##1
		(o_rsp_byte == id3_q && o_rsp_last))
		else $error("ident bytes out of order");
	AST_PERR_CLEAR: assert property ((o_rsp_valid && o_rsp_last && $past(rsp_perr_q) && !$past(perr_event)) // [RULE10]
		|-> (perr_cnt_q == 7'h00 && !perr_ovf_q && !sig_perr_q))
		else $error("parity count not cleared after read");
	AST_PERR_COUNT: assert property ((perr_event && state_q == display_cmd_pkg::ST_IDLE && // [RULE9]
		rsp_left_q == 2'h0 && perr_cnt_q < 7'h7f) |=> perr_cnt_q == $past(perr_cnt_q) + 7'h01)
		else $error("parity error not counted");
	AST_RED_16: assert property ((i_cmd_valid && accept && i_cmd_byte == 8'h06 && fmt_q[2:0] == 3'h5) // [RULE11]
		|=> ##1 (o_rsp_byte[7:6] == 2'b00 && o_rsp_byte[0] == 1'b0))
		else $error("red readback unused bits set");
	// Undefined format codes read back as 24-bit, so only the two narrow formats are checked
	AST_GREEN_18: assert property ((i_cmd_valid && accept && i_cmd_byte == 8'h07 && // [RULE12]
		(fmt_q[2:0] == `FMT_16BIT || fmt_q[2:0] == `FMT_18BIT)) |=> ##1 (o_rsp_byte[7:6] == 2'b00))
		else $error("green readback top bits set");
	AST_POWER_BIT3: assert property ((state_q == display_cmd_pkg::ST_WAIT && // [RULE23] [RULE14]
		$past(state_q) == display_cmd_pkg::ST_LOAD) |-> (power_mode == `POWER_MODE_RST))
		else $error("power byte not at its default after soft reset");
	AST_WAIT_IGNORE: assert property ((state_q == display_cmd_pkg::ST_WAIT && ctrl_q[0] && // [RULE24]
		i_cmd_valid && i_cmd_byte == 8'h29) |=> !disp_q)
		else $error("command taken during reset wait");

	COV_SWRST: cover property ((state_q == display_cmd_pkg::ST_WAIT) ##1 (state_q == display_cmd_pkg::ST_IDLE));
	COV_IDENT: cover property (o_rsp_valid && o_rsp_last && rsp_left_q == 2'h0);
	COV_PERR_OVF: cover property (perr_ovf_q);
	COV_PERR_RACE: cover property (perr_event && rsp_perr_q && rsp_left_q == 2'h1);

endmodule : display_cmd_handler

// [hdl/display_cmd_regs.svh]
// Offsets, reset values, field positions and timing counts of the command handler
`ifndef DISPLAY_CMD_REGS_SVH
`define DISPLAY_CMD_REGS_SVH

`define REG_STATUS_OFS      8'h00
`define REG_CTRL_OFS        8'h04
`define REG_MODES_OFS       8'h08
`define REG_PERR_OFS        8'h0c
`define CTRL_RST            8'h01
`define CTRL_IGNORE_BIT     0

`define POWER_MODE_RST      8'h08
`define PIXEL_FORMAT_RST    8'h07
`define ACCESS_CTRL_RST     8'h00
`define GAMMA_RST           8'h01
`define BYTE_ZERO_RST       8'h00
`define WORD_ZERO_RST       16'h0000

`define PWR_BOOST_BIT       7
`define PWR_IDLE_BIT        6
`define PWR_SLEEP_OUT_BIT   4
`define PWR_NORMAL_BIT      3
`define PWR_DISP_ON_BIT     2
`define SIG_TE_ON_BIT       7
`define SIG_TE_MODE_BIT     6
`define SIG_PERR_BIT        0
`define PERR_OVF_BIT        7
`define PERR_MAX            7'h7f

`define FMT_16BIT           3'h5
`define FMT_18BIT           3'h6
`define FMT_24BIT           3'h7

`define CLK_PERIOD_NS       4
`define SWRST_WAIT_MS       5
`define SWRST_WAIT_CYCLES   (`SWRST_WAIT_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// [hdl/display_cmd_pkg.sv]
// Types of the display command handler: sequencer states and command codes
package display_cmd_pkg;

	typedef enum logic [2:0] {
		ST_OTP   = 3'b000,
		ST_IDLE  = 3'b001,
		ST_BLANK = 3'b010,
		ST_LOAD  = 3'b011,
		ST_WAIT  = 3'b100
	} state_type;

	typedef enum logic [7:0] {
		NOP_CMD                   = 8'h00,
		SOFT_RESET_CMD            = 8'h01,
		READ_IDENT_INFO_CMD       = 8'h04,
		READ_PARITY_ERR_COUNT_CMD = 8'h05,
		READ_FIRST_PIXEL_RED_CMD  = 8'h06,
		READ_FIRST_PIXEL_GREEN_CMD = 8'h07,
		READ_FIRST_PIXEL_BLUE_CMD = 8'h08,
		READ_POWER_MODE_CMD       = 8'h0a,
		READ_ACCESS_CONTROL_CMD   = 8'h0b,
		READ_PIXEL_FORMAT_CMD     = 8'h0c,
		READ_SIGNAL_MODE_CMD      = 8'h0e,
		SLEEP_ENTER_CMD           = 8'h10,
		SLEEP_EXIT_CMD            = 8'h11,
		FULL_AREA_MODE_ON_CMD     = 8'h13,
		INVERSION_OFF_CMD         = 8'h20,
		INVERSION_ON_CMD          = 8'h21,
		FORCE_PIXELS_DARK_CMD     = 8'h22,
		FORCE_PIXELS_LIT_CMD      = 8'h23,
		GAMMA_CURVE_SELECT        = 8'h26,
		PANEL_OUTPUT_OFF_CMD      = 8'h28,
		PANEL_OUTPUT_ON_CMD       = 8'h29,
		TEAR_OUTPUT_OFF_CMD       = 8'h34,
		TEAR_OUTPUT_ON_CMD        = 8'h35,
		MEMORY_ACCESS_CONTROL     = 8'h36,
		VERTICAL_SCROLL_ADDRESS   = 8'h37,
		LOW_COLOR_OFF_CMD         = 8'h38,
		LOW_COLOR_ON_CMD          = 8'h39,
		INTERFACE_PIXEL_FORMAT    = 8'h3a,
		TEAR_SCANLINE_SET         = 8'h44,
		CURRENT_SCANLINE_READ     = 8'h45,
		BRIGHTNESS_VALUE_WRITE    = 8'h51,
		BRIGHTNESS_VALUE_READ     = 8'h52,
		DISPLAY_CTRL_WRITE        = 8'h53,
		DISPLAY_CTRL_READ         = 8'h54,
		ADAPTIVE_BRIGHTNESS_WRITE = 8'h55,
		ADAPTIVE_BRIGHTNESS_READ  = 8'h56,
		ADAPTIVE_MIN_BRIGHTNESS_WRITE = 8'h5e,
		ADAPTIVE_MIN_BRIGHTNESS_READ  = 8'h5f,
		IDENT_BYTE_ONE_READ       = 8'hda,
		IDENT_BYTE_TWO_READ       = 8'hdb,
		IDENT_BYTE_THREE_READ     = 8'hdc
	} cmd_type;

endpackage : display_cmd_pkg

// [dv/host_model.sv]
// Host model: command and parameter strobes, parity-error line, link clock
`timescale 1ns/10ps
module host_model #(
	parameter int WAIT_CYCLES = 20
) (
	input  wire logic       i_clk,
	output logic            o_cmd_valid,
	output logic      [7:0] o_cmd_byte,
	output logic            o_param_valid,
	output logic      [7:0] o_param_byte,
	output logic            o_link_clk,
	output logic            o_link_perr
);
	initial begin
		o_cmd_valid = 1'h0;
		o_cmd_byte = 8'h00;
		o_param_valid = 1'h0;
		o_param_byte = 8'h00;
		o_link_clk = 1'h0;
		o_link_perr = 1'h0;
	end
	task automatic cmd(input logic [7:0] c);
		@(posedge i_clk);
		o_cmd_valid <= 1'h1;
		o_cmd_byte <= c;
		@(posedge i_clk);
		o_cmd_valid <= 1'h0;
		o_cmd_byte <= ~c;
	endtask : cmd
	task automatic prm(input logic [7:0] p);
		@(posedge i_clk);
		o_param_valid <= 1'h1;
		o_param_byte <= p;
		@(posedge i_clk);
		o_param_valid <= 1'h0;
		o_param_byte <= ~p;
	endtask : prm
	// Only sent from sleep-in; no sleep exit follows; t_swrst sends a panel-on during the wait
	task automatic soft_reset();
		cmd(8'h01);
		repeat (WAIT_CYCLES + 8) @(posedge i_clk);
	endtask : soft_reset
	// Link clock runs only while errors are flagged
	task automatic errors(input int n);
		o_link_perr = 1'h1;
		repeat (n) begin
			#40 o_link_clk = 1'h1;
			#40 o_link_clk = 1'h0;
		end
		o_link_perr = 1'h0;
	endtask : errors
endmodule : host_model

// [dv/tb.sv]
// Testbench of the display command handler
`timescale 1ns/10ps
module tb;
	localparam int WAIT_CYC = 20;
	logic        i_clk = 1'h0, i_arst_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
	logic [7:0]  i_addr = 8'h00, q[3];
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic [7:0]  pr = 8'hb7, pg = 8'h6d, pb = 8'hca, rb, fmt, acc, gam, bri, cb, pm;
	logic        cv, pv, lc, pe, rv, rl, sl, dn, nm, inv, idl, lit, te, bsy, pmod = 1'h1;
	logic [7:0]  id1 = 8'h5a, id3 = 8'h3c;
	logic [6:0]  ver = 7'h13;
	logic [15:0] scan = 16'h2c4e;
	int          miscompares = 0, n_checks = 0;
	always #2 i_clk = ~i_clk;
	host_model #(.WAIT_CYCLES(WAIT_CYC)) HOST (.i_clk, .o_cmd_valid(cv), .o_cmd_byte(cb),
		.o_param_valid(pv), .o_param_byte(pm), .o_link_clk(lc), .o_link_perr(pe));
	// Storage ident values are arbitrary
	display_cmd_handler #(.SWRST_WAIT_CYCLES(WAIT_CYC)) DUT (.i_clk, .i_arst_n, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .i_cmd_valid(cv), .i_cmd_byte(cb),
		.i_param_valid(pv), .i_param_byte(pm), .o_rsp_valid(rv), .o_rsp_byte(rb),
		.o_rsp_last(rl), .i_link_clk(lc), .i_link_perr(pe), .i_pix_red(pr),
		.i_pix_green(pg), .i_pix_blue(pb), .i_scanline(scan), .i_otp_id1(id1),
		.i_otp_panel_module(pmod), .i_otp_version(ver), .i_otp_id3(id3), .o_busy(bsy),
		.o_sleep_in(sl), .o_display_on(dn), .o_normal_mode(nm), .o_inversion_on(inv),
		.o_idle_on(idl), .o_all_lit(lit), .o_tear_on(te), .o_pixel_format(fmt),
		.o_access_ctrl(acc), .o_gamma(gam), .o_brightness(bri));
	task automatic chk(input string s, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'h0;
		i_rd <= 1'h0;
		@(negedge i_clk);
		if (!w) chk("rdata", o_rdata, d);
	endtask : bus
	task automatic rsp(input logic [7:0] c, input int n);
		int k;
		k = 0;
		HOST.cmd(c);
		repeat (20) begin
			@(negedge i_clk);
			if (rv === 1'h1 && k < n) begin
				q[k] = rb;
				chk("last", rl, k == n - 1);
				k++;
			end
		end
		chk("bytes", k, n);
	endtask : rsp
	task automatic t_reset();
		chk("modes", {sl, nm, dn, inv, idl, lit, te}, 7'h60);
		chk("fmt", fmt, 8'h07);
		chk("acc", acc, 8'h00);
		chk("gam", gam, 8'h01);
		chk("bri", bri, 8'h00);
		chk("busy", bsy, 1'h0);
		bus(1'h1, 8'h04, 32'h0);
		bus(1'h0, 8'h04, 32'h0);
		bus(1'h0, 8'h08, 32'h8);
		bus(1'h0, 8'h10, 32'h0);
		rsp(8'h0a, 1);
		chk("pwr", q[0], 8'h08);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_ident();
		rsp(8'h04, 3);
		chk("id", {q[0], q[1], q[2]}, 24'h5a933c);
		rsp(8'h45, 2);
		chk("scan", {q[0], q[1]}, 16'h2c4e);
		$display("t_ident done");
	endtask : t_ident
	task automatic t_parity();
		HOST.errors(3);
		repeat (8) @(posedge i_clk);
		bus(1'h0, 8'h0c, 32'h3);
		bus(1'h0, 8'h08, 32'h108);
		rsp(8'h05, 1);
		chk("perr", q[0], 8'h03);
		bus(1'h0, 8'h0c, 32'h0);
		bus(1'h0, 8'h08, 32'h8);
		$display("t_parity done");
	endtask : t_parity
	task automatic t_colour();
		rsp(8'h06, 1);
		chk("r24", q[0], pr);
		rsp(8'h07, 1);
		chk("g24", q[0], pg);
		rsp(8'h08, 1);
		chk("b24", q[0], pb);
		@(posedge i_clk);
		{pr, pg, pb} <= 24'h4b9335;
		HOST.cmd(8'h3a);
		HOST.prm(8'h55);
		HOST.cmd(8'h00);
		chk("nop", fmt, 8'h55);
		rsp(8'h06, 1);
		chk("r16", q[0], {2'h0, pr[7:3], 1'h0});
		rsp(8'h07, 1);
		chk("g16", q[0], {2'h0, pg[7:2]});
		rsp(8'h08, 1);
		chk("b16", q[0], {2'h0, pb[7:3], 1'h0});
		HOST.cmd(8'h3a);
		HOST.prm(8'h66);
		rsp(8'h08, 1);
		chk("b18", q[0], {2'h0, pb[7:2]});
		$display("t_colour done");
	endtask : t_colour
	task automatic t_swrst();
		HOST.cmd(8'h36);
		HOST.prm(8'h40);
		HOST.cmd(8'h26);
		HOST.prm(8'h02);
		HOST.cmd(8'h51);
		HOST.prm(8'h11);
		HOST.cmd(8'h29);
		HOST.cmd(8'h21);
		HOST.cmd(8'h23);
		HOST.cmd(8'h35);
		HOST.cmd(8'h39);
		@(negedge i_clk);
		chk("pre", {dn, gam, bri}, 17'h10211);
		chk("on", {inv, lit, te, idl}, 4'hf);
		bus(1'h1, 8'h04, 32'h1);
		@(posedge i_clk);
		{id1, pmod, ver, id3} <= 24'ha52ec3;
		// A panel-on sent inside the wait must be dropped while the ignore bit is set
		fork
			HOST.soft_reset();
			begin
				repeat (6) @(posedge i_clk);
				HOST.cmd(8'h29);
				chk("busy", bsy, 1'h1);
			end
		join
		chk("sw", {sl, dn, fmt, acc}, 18'h26640);
		chk("swdef", {gam, bri}, 16'h0100);
		chk("off", {inv, lit, te, idl, bsy}, 5'h00);
		rsp(8'h04, 3);
		chk("id2", {q[0], q[1], q[2]}, 24'ha52ec3);
		$display("t_swrst done");
	endtask : t_swrst
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1'h1;
		repeat (2) @(posedge i_clk);
		t_reset();
		t_ident();
		t_parity();
		t_colour();
		t_swrst();
		finish_test();
	end
	initial begin
		#200000;
		miscompares++;
		finish_test();
	end
endmodule : tb
